//--- hw/cdb_map.svh
// Purpose: register offsets, field positions, reset values and lock levels
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes:   definitions only
`ifndef CDB_MAP_SVH
`define CDB_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CDB_OFF_BRK 8'h00
`define CDB_OFF_ENA 8'h04
`define CDB_OFF_POL 8'h08
`define CDB_OFF_MODE 8'h0c
`define CDB_OFF_DT 8'h10
`define CDB_OFF_EVT 8'h14
`define CDB_OFF_STAT 8'h18
`define CDB_OFF_IRQ 8'h1c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CDB_BRK_MOE 0
`define CDB_BRK_AOE 1
`define CDB_BRK_BKE 2
`define CDB_BRK_BKP 3
`define CDB_BRK_IDLE_OFF_STATE_SELECT 4
`define CDB_BRK_RUN_OFF_STATE_SELECT 5
`define CDB_BRK_LOCK 6
`define CDB_ENA_COMP 8
`define CDB_ENA_ACT_MAIN 16
`define CDB_ENA_ACT_COMP 24
`define CDB_POL_COMP 8
`define CDB_POL_IDLE_MAIN 16
`define CDB_POL_IDLE_COMP 24
`define CDB_EVT_COMMUTATION_GENERATE 0
`define CDB_STAT_COM 0
`define CDB_STAT_BRK 1
`define CDB_STAT_LEVEL 2
`define CDB_IRQ_COM 0
`define CDB_IRQ_BRK 1

// ----------------------------------------------------------------------
// reset values, lock thresholds, mode field width and channel limit
// ----------------------------------------------------------------------
`define CDB_RST_DT 8'h00
`define CDB_RST_LOCK 2'h0
`define CDB_LOCK_L1 2'h1
`define CDB_LOCK_L2 2'h2
`define CDB_LOCK_L3 2'h3
`define CDB_MODE_W 3
`define CDB_MAX_CH 8

`endif

//--- hw/cdb_output_stage.sv
// Purpose: complementary output stage with deadtime, commutation preload and break
// Assumes: reference waveforms, trigger and update event come from logic on CLK_SYS_I
// Notes:   the break pin acts asynchronously on the master enable and the output stage
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "cdb_map.svh"

module cdb_output_stage #(
  parameter int NCH = 4,
  parameter int AW = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [NCH-1:0] REF_WAVE_I,
  input wire logic UPDATE_EVENT_I,
  input wire logic TRIGGER_I,
  input wire logic BREAK_PIN_I,
  output logic [NCH-1:0] MAIN_OUT_O,
  output logic [NCH-1:0] COMP_OUT_O,
  output logic [NCH-1:0] MAIN_OE_O,
  output logic [NCH-1:0] COMP_OE_O,
  output logic [3*NCH-1:0] COMPARE_MODE_O,
  output logic COM_IRQ_O,
  output logic BRK_IRQ_O
);

  if (NCH < 1 || NCH > `CDB_MAX_CH || AW < 8) begin : g_bad_cfg
    $error("cdb_output_stage: unsupported channel count or address width");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  cdb_pkg::cdb_brk_cfg_t brk_q;
  cdb_pkg::cdb_chan_cfg_t pre_q [NCH];
  cdb_pkg::cdb_chan_cfg_t act_cfg_q [NCH];
  logic lock_done_q, moe_q, moe_s1_q, moe_s2_q, brk_s1_q, brk_s2_q;
  logic com_flag_q, brk_flag_q, com_ie_q, brk_ie_q, trig_q, ack_q;
  logic [NCH-1:0] pol_main_q, pol_comp_q, idle_main_q, idle_comp_q;
  logic [NCH-1:0] act_main_q, act_comp_q, oe_main_q, oe_comp_q;
  logic [7:0] dt_q;
  logic [31:0] dat_q;

  // ----------------------------------------------------------------------
  // break detection
  // ----------------------------------------------------------------------
  logic brk_async, brk_kill;
  assign brk_async = brk_q.break_enable & (BREAK_PIN_I == brk_q.break_polarity);
  // blank the outputs only while the run path may still drive them
  assign brk_kill = brk_async & (moe_s1_q | moe_s2_q);

  // ----------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------
  logic req, wr, com_ev, lock1, lock2, lock3;
  logic wr_brk, wr_ena, wr_pol, wr_mode, wr_dt, wr_stat, wr_irq;
  logic [7:0] adr;
  logic [31:0] rdv, wv;
  function automatic logic [31:0] wb_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction
  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr = req & WB_WE_I;
  assign adr = WB_ADR_I[7:0];
  assign wr_brk = wr & (adr == `CDB_OFF_BRK);
  assign wr_ena = wr & (adr == `CDB_OFF_ENA);
  assign wr_pol = wr & (adr == `CDB_OFF_POL);
  assign wr_mode = wr & (adr == `CDB_OFF_MODE);
  assign wr_dt = wr & (adr == `CDB_OFF_DT);
  assign wr_stat = wr & (adr == `CDB_OFF_STAT);
  assign wr_irq = wr & (adr == `CDB_OFF_IRQ);
  assign lock1 = brk_q.lock >= `CDB_LOCK_L1;
  assign lock2 = brk_q.lock >= `CDB_LOCK_L2;
  assign lock3 = brk_q.lock == `CDB_LOCK_L3;
  always_comb begin
    rdv = 32'h0000_0000;
    unique case (adr)
      `CDB_OFF_BRK: begin
        rdv[`CDB_BRK_MOE] = moe_s2_q;
        rdv[`CDB_BRK_AOE] = brk_q.auto_output_reenable;
        rdv[`CDB_BRK_BKE] = brk_q.break_enable;
        rdv[`CDB_BRK_BKP] = brk_q.break_polarity;
        rdv[`CDB_BRK_IDLE_OFF_STATE_SELECT] = brk_q.idle_off_state_select;
        rdv[`CDB_BRK_RUN_OFF_STATE_SELECT] = brk_q.run_off_state_select;
        rdv[`CDB_BRK_LOCK +: 2] = brk_q.lock;
      end
      `CDB_OFF_ENA: begin
        for (int i = 0; i < NCH; i++) begin
          rdv[i] = pre_q[i].main_en;
          rdv[`CDB_ENA_COMP + i] = pre_q[i].comp_en;
          rdv[`CDB_ENA_ACT_MAIN + i] = act_cfg_q[i].main_en;
          rdv[`CDB_ENA_ACT_COMP + i] = act_cfg_q[i].comp_en;
        end
      end
      `CDB_OFF_POL: begin
        rdv[NCH-1:0] = pol_main_q;
        rdv[`CDB_POL_COMP +: NCH] = pol_comp_q;
        rdv[`CDB_POL_IDLE_MAIN +: NCH] = idle_main_q;
        rdv[`CDB_POL_IDLE_COMP +: NCH] = idle_comp_q;
      end
      `CDB_OFF_MODE: begin
        for (int i = 0; i < NCH; i++) begin
          rdv[`CDB_MODE_W*i +: `CDB_MODE_W] = pre_q[i].mode;
        end
      end
      `CDB_OFF_DT: rdv[7:0] = dt_q;
      `CDB_OFF_STAT: begin
        rdv[`CDB_STAT_COM] = com_flag_q;
        rdv[`CDB_STAT_BRK] = brk_flag_q;
        rdv[`CDB_STAT_LEVEL] = brk_s2_q;
      end
      `CDB_OFF_IRQ: begin
        rdv[`CDB_IRQ_COM] = com_ie_q;
        rdv[`CDB_IRQ_BRK] = brk_ie_q;
      end
      default: rdv = 32'h0000_0000;
    endcase
  end
  assign wv = wb_merge(rdv, WB_DAT_I, WB_SEL_I);
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= rdv;
    end
  end

  // ----------------------------------------------------------------------
  // break configuration and protection level
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      brk_q <= '0;
      lock_done_q <= 1'b0;
    end else if (wr_brk) begin
      if (!lock1) begin
        brk_q.auto_output_reenable <= wv[`CDB_BRK_AOE];
        brk_q.break_enable <= wv[`CDB_BRK_BKE];
        brk_q.break_polarity <= wv[`CDB_BRK_BKP];
      end
      if (!lock2) begin
        brk_q.idle_off_state_select <= wv[`CDB_BRK_IDLE_OFF_STATE_SELECT];
        brk_q.run_off_state_select <= wv[`CDB_BRK_RUN_OFF_STATE_SELECT];
      end
      if (!lock_done_q) begin
        brk_q.lock <= wv[`CDB_BRK_LOCK +: 2];
        lock_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // master output enable and its resynchronisation
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I or posedge brk_async) begin
    if (!RST_N_I) begin
      moe_q <= 1'b0;
    end else if (brk_async) begin
      moe_q <= 1'b0;
    end else if (wr_brk) begin
      moe_q <= wv[`CDB_BRK_MOE];
    end else if (brk_q.auto_output_reenable && UPDATE_EVENT_I) begin
      moe_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      moe_s1_q <= 1'b0;
      moe_s2_q <= 1'b0;
      brk_s1_q <= 1'b0;
      brk_s2_q <= 1'b0;
    end else begin
      moe_s1_q <= moe_q;
      moe_s2_q <= moe_s1_q;
      brk_s1_q <= brk_async;
      brk_s2_q <= brk_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // polarity, idle levels, deadtime setting, interrupt enables
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pol_main_q <= '0;
      pol_comp_q <= '0;
      idle_main_q <= '0;
      idle_comp_q <= '0;
      dt_q <= `CDB_RST_DT;
      com_ie_q <= 1'b0;
      brk_ie_q <= 1'b0;
    end else begin
      if (wr_pol && !lock2) begin
        pol_main_q <= wv[NCH-1:0];
        pol_comp_q <= wv[`CDB_POL_COMP +: NCH];
      end
      if (wr_pol && !lock1) begin
        idle_main_q <= wv[`CDB_POL_IDLE_MAIN +: NCH];
        idle_comp_q <= wv[`CDB_POL_IDLE_COMP +: NCH];
      end
      if (wr_dt && !lock1) begin
        dt_q <= wv[7:0];
      end
      if (wr_irq) begin
        com_ie_q <= wv[`CDB_IRQ_COM];
        brk_ie_q <= wv[`CDB_IRQ_BRK];
      end
    end
  end

  // ----------------------------------------------------------------------
  // commutation: preload and transfer
  // ----------------------------------------------------------------------
  assign com_ev = (wr && adr == `CDB_OFF_EVT && wv[`CDB_EVT_COMMUTATION_GENERATE])
                  | (TRIGGER_I & ~trig_q);

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trig_q <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        pre_q[i] <= '0;
        act_cfg_q[i] <= '0;
      end
    end else begin
      trig_q <= TRIGGER_I;
      for (int i = 0; i < NCH; i++) begin
        if (wr_ena) begin
          pre_q[i].main_en <= wv[i];
          pre_q[i].comp_en <= wv[`CDB_ENA_COMP + i];
        end
        if (wr_mode && !lock3) begin
          pre_q[i].mode <= wv[`CDB_MODE_W*i +: `CDB_MODE_W];
        end
      end
      if (com_ev) begin
        for (int i = 0; i < NCH; i++) begin
          act_cfg_q[i] <= pre_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // status flags and interrupt requests; a set beats a clear
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      com_flag_q <= 1'b0;
      brk_flag_q <= 1'b0;
      COM_IRQ_O <= 1'b0;
      BRK_IRQ_O <= 1'b0;
    end else begin
      if (com_ev) begin
        com_flag_q <= 1'b1;
      end else if (wr_stat && !wv[`CDB_STAT_COM]) begin
        com_flag_q <= 1'b0;
      end
      if (brk_s2_q) begin
        brk_flag_q <= 1'b1;
      end else if (wr_stat && !wv[`CDB_STAT_BRK]) begin
        brk_flag_q <= 1'b0;
      end
      COM_IRQ_O <= com_flag_q & com_ie_q;
      BRK_IRQ_O <= brk_flag_q & brk_ie_q;
    end
  end

  // ----------------------------------------------------------------------
  // per-channel steering and deadtime generator
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic want_m, want_c, use_dt, en_m, en_c, prev_m_q, prev_c_q, chg;
    logic [8:0] cnt_q, cnt_d;
    always_comb begin
      want_m = 1'b0;
      want_c = 1'b0;
      use_dt = 1'b0;
      en_m = brk_q.run_off_state_select;
      en_c = brk_q.run_off_state_select;
      if (!moe_s2_q) begin
        want_m = idle_main_q[g] ^ pol_main_q[g];
        want_c = (idle_comp_q[g] ^ pol_comp_q[g]) & ~want_m;
        use_dt = 1'b1;
        en_m = brk_q.idle_off_state_select;
        en_c = brk_q.idle_off_state_select;
      end else if (act_cfg_q[g].main_en && act_cfg_q[g].comp_en) begin
        want_m = REF_WAVE_I[g];
        want_c = ~REF_WAVE_I[g];
        use_dt = 1'b1;
        en_m = 1'b1;
        en_c = 1'b1;
      end else if (act_cfg_q[g].main_en) begin
        want_m = REF_WAVE_I[g];
        en_m = 1'b1;
      end else if (act_cfg_q[g].comp_en) begin
        want_c = REF_WAVE_I[g];
        en_c = 1'b1;
      end
    end

    // restart the deadtime while the master enable crosses its resync stages
    assign chg = (want_m != prev_m_q) | (want_c != prev_c_q) | (moe_s1_q ^ moe_s2_q);
    assign cnt_d = chg ? 9'h001 : (cnt_q[8] ? cnt_q : cnt_q + 9'h001);

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        prev_m_q <= 1'b0;
        prev_c_q <= 1'b0;
        cnt_q <= 9'h000;
        oe_main_q[g] <= 1'b0;
        oe_comp_q[g] <= 1'b0;
      end else begin
        prev_m_q <= want_m;
        prev_c_q <= want_c;
        cnt_q <= cnt_d;
        oe_main_q[g] <= en_m;
        oe_comp_q[g] <= en_c;
      end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I or posedge brk_kill) begin
      if (!RST_N_I) begin
        act_main_q[g] <= 1'b0;
        act_comp_q[g] <= 1'b0;
      end else if (brk_kill) begin
        act_main_q[g] <= 1'b0;
        act_comp_q[g] <= 1'b0;
      end else begin
        // a pulse ends before the count reaches the setting and never shows
        act_main_q[g] <= want_m & (!use_dt || cnt_d > {1'b0, dt_q});
        act_comp_q[g] <= want_c & (!use_dt || cnt_d > {1'b0, dt_q});
      end
    end

    assign MAIN_OUT_O[g] = act_main_q[g] ^ pol_main_q[g];
    assign COMP_OUT_O[g] = act_comp_q[g] ^ pol_comp_q[g];
    assign COMPARE_MODE_O[`CDB_MODE_W*g +: `CDB_MODE_W] = act_cfg_q[g].mode;
  end

  assign MAIN_OE_O = oe_main_q;
  assign COMP_OE_O = oe_comp_q;
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

endmodule
`default_nettype wire

//--- hw/cdb_pkg.sv
// Purpose: types shared by the output stage
// Assumes: constants come from cdb_map.svh
// Notes:   none
package cdb_pkg;

  typedef struct packed {
    logic [2:0] mode;
    logic main_en;
    logic comp_en;
  } cdb_chan_cfg_t;

  typedef struct packed {
    logic auto_output_reenable;
    logic break_enable;
    logic break_polarity;
    logic idle_off_state_select;
    logic run_off_state_select;
    logic [1:0] lock;
  } cdb_brk_cfg_t;

endpackage

//--- tb/cdb_break_source.sv
// Purpose: far side model: break alarm source and shoot-through watch on the gate drivers
// Assumes: alarm request comes from the bench; pins seen at pin level
// Notes:   the alarm acts on the pin at once, with no clock involved
`timescale 1ns/1ps
`default_nettype none

module cdb_break_source #(
  parameter int NCH = 4,
  parameter logic ACTIVE_LVL = 1'b1
) (
  input wire logic clk_i,
  input wire logic alarm_i,
  input wire logic [NCH-1:0] main_i,
  input wire logic [NCH-1:0] comp_i,
  output logic break_pin_o,
  output logic shoot_o
);
  // ----------------------------------------------------------------------
  // alarm pin and overlap watch
  // ----------------------------------------------------------------------
  assign break_pin_o = alarm_i ? ACTIVE_LVL : ~ACTIVE_LVL;
  initial shoot_o = 1'b0;
  // both switches of a leg on would short the supply
  always @(posedge clk_i) begin
    if (|(main_i & comp_i)) begin
      shoot_o <= 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- tb/cdb_output_stage_asserts.sv
// Purpose: port-level checker for the output stage
// Assumes: full byte selects on writes; polarity lock level 2 and up never used
// Notes:   shadows a few control bits from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "cdb_map.svh"

module cdb_output_stage_asserts #(
  parameter int NCH = 4,
  parameter int AW = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [NCH-1:0] REF_WAVE_I,
  input wire logic UPDATE_EVENT_I,
  input wire logic TRIGGER_I,
  input wire logic BREAK_PIN_I,
  input wire logic [NCH-1:0] MAIN_OUT_O,
  input wire logic [NCH-1:0] COMP_OUT_O,
  input wire logic [NCH-1:0] MAIN_OE_O,
  input wire logic [NCH-1:0] COMP_OE_O,
  input wire logic [3*NCH-1:0] COMPARE_MODE_O,
  input wire logic COM_IRQ_O,
  input wire logic BRK_IRQ_O
);
  // ----------------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------------
  logic [NCH-1:0] pol_m_q, pol_c_q, act_m, act_c;
  logic [7:0] dt_q;
  logic [8:0] ref_hi_q;
  logic [1:0] lock_q;
  logic first_q, bke_q, bkp_q, com_ie_q, bie_q, trig_q, wr, com_evt, brk;
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
  assign com_evt = (wr & (WB_ADR_I[7:0] == `CDB_OFF_EVT) & WB_DAT_I[0]) | (TRIGGER_I & ~trig_q);
  assign brk = bke_q & (BREAK_PIN_I == bkp_q);
  assign act_m = MAIN_OUT_O ^ pol_m_q;
  assign act_c = COMP_OUT_O ^ pol_c_q;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trig_q <= 1'b0;
      ref_hi_q <= 9'h000;
    end else begin
      trig_q <= TRIGGER_I;
      ref_hi_q <= REF_WAVE_I[0] ? ref_hi_q + {8'h00, ref_hi_q != 9'h1ff} : 9'h000;
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {pol_m_q, pol_c_q, dt_q, lock_q, first_q, bke_q, bkp_q, com_ie_q, bie_q} <= '0;
    end else if (wr) begin
      case (WB_ADR_I[7:0])
        `CDB_OFF_POL: {pol_c_q, pol_m_q} <= {WB_DAT_I[8+:NCH], WB_DAT_I[NCH-1:0]};
        `CDB_OFF_DT: if (lock_q == 2'h0) dt_q <= WB_DAT_I[7:0];
        `CDB_OFF_IRQ: {bie_q, com_ie_q} <= WB_DAT_I[1:0];
        `CDB_OFF_BRK: begin
          first_q <= 1'b1;
          if (!first_q) lock_q <= WB_DAT_I[7:6];
          if (!first_q || lock_q == 2'h0) {bkp_q, bke_q} <= WB_DAT_I[3:2];
        end
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("request not answered in the next cycle");
  a_never_both_on: assert property ((act_m & act_c) == '0)
    else $error("main and complementary active together");
  a_main_dead_delay: assert property (($rose(act_m[0]) && MAIN_OE_O[0] && COMP_OE_O[0])
    |-> ref_hi_q > {1'b0, dt_q})
    else $error("main rose before the deadtime ran out");
  a_mode_at_commut: assert property ($changed(COMPARE_MODE_O) |-> $past(com_evt))
    else $error("compare mode changed without a commutation");
  a_com_irq_raise: assert property ((com_evt && com_ie_q) |-> ##2 COM_IRQ_O)
    else $error("commutation interrupt missing");
  a_break_safe_now: assert property ((brk && !$past(brk)) |-> (act_m | act_c) == '0)
    else $error("outputs active when break arrived");
  a_brk_irq_raise: assert property ((brk && bie_q) |-> ##[1:5] BRK_IRQ_O)
    else $error("break interrupt missing");
  c_break_seen: cover property (brk && !$past(brk));
  c_commut_irq: cover property (com_evt && com_ie_q);
  c_dead_rise: cover property ($rose(act_m[0]) && MAIN_OE_O[0] && COMP_OE_O[0]);
endmodule

bind cdb_output_stage cdb_output_stage_asserts #(.NCH(NCH), .AW(AW)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .REF_WAVE_I(REF_WAVE_I),
  .UPDATE_EVENT_I(UPDATE_EVENT_I), .TRIGGER_I(TRIGGER_I), .BREAK_PIN_I(BREAK_PIN_I),
  .MAIN_OUT_O(MAIN_OUT_O), .COMP_OUT_O(COMP_OUT_O), .MAIN_OE_O(MAIN_OE_O),
  .COMP_OE_O(COMP_OE_O), .COMPARE_MODE_O(COMPARE_MODE_O), .COM_IRQ_O(COM_IRQ_O),
  .BRK_IRQ_O(BRK_IRQ_O));

`default_nettype wire

//--- tb/cdb_output_stage_tb.sv
// Purpose: self-checking bench for the output stage
// Assumes: deadtime 3 cycles; break pin active high
// Notes:   register access through classic Wishbone single cycles
`timescale 1ns/1ps
`default_nettype none
`include "cdb_map.svh"

module cdb_output_stage_tb;
  // ----------------------------------------------------------------------
  // bench signals, tasks and sequence
  // ----------------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, upd = 1'b0;
  logic trig = 1'b0, alarm = 1'b0, brk_pin, shoot, com_irq, brk_irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] ref_w = 4'h0, main_o, comp_o, main_oe, comp_oe;
  logic [11:0] cmode;
  int errors = 0, cmp_count = 0, cyc_cnt = 0, n;
  always #5 clk = ~clk;

  cdb_output_stage #(.NCH(4), .AW(8)) dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .REF_WAVE_I(ref_w), .UPDATE_EVENT_I(upd), .TRIGGER_I(trig), .BREAK_PIN_I(brk_pin),
    .MAIN_OUT_O(main_o), .COMP_OUT_O(comp_o), .MAIN_OE_O(main_oe), .COMP_OE_O(comp_oe),
    .COMPARE_MODE_O(cmode), .COM_IRQ_O(com_irq), .BRK_IRQ_O(brk_irq));
  cdb_break_source #(.NCH(4), .ACTIVE_LVL(1'b1)) u_far (
    .clk_i(clk), .alarm_i(alarm), .main_i(main_o), .comp_i(comp_o),
    .break_pin_o(brk_pin), .shoot_o(shoot));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) errors++;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // edges until the chosen ch0 pin reaches lvl, capped at 40
  task automatic meas(input logic comp, input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (((comp ? comp_o[0] : main_o[0]) !== lvl) && k < 40);
  endtask
  task automatic set_ref(input logic v);
    @(posedge clk);
    ref_w[0] <= v;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    logic hi;
    waitc(20);
    rst_n <= 1'b1;
    rd(`CDB_OFF_BRK, 32'h0, "brk reset");
    rd(`CDB_OFF_ENA, 32'h0, "ena reset");
    rd(`CDB_OFF_STAT, 32'h0, "stat reset");
    rd(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    wr(`CDB_OFF_IRQ, 32'h1);
    wr(`CDB_OFF_MODE, 32'h6);
    wr(`CDB_OFF_ENA, 32'h0101);
    chk("mode before event", {20'h0, cmode}, 32'h0);
    wr(`CDB_OFF_EVT, 32'h1);
    chk("mode after event", {20'h0, cmode}, 32'h6);
    rd(`CDB_OFF_ENA, 32'h01010101, "ena active");
    rd(`CDB_OFF_STAT, 32'h1, "com flag");
    chk("com irq", {31'h0, com_irq}, 32'h1);
    wr(`CDB_OFF_MODE, 32'h3);
    @(posedge clk);
    trig <= 1'b1;
    waitc(2);
    trig <= 1'b0;
    #1;
    chk("mode after trigger", {20'h0, cmode}, 32'h3);
    $display("test commutation done");
    wr(`CDB_OFF_DT, 32'h3);
    wr(`CDB_OFF_BRK, 32'h0d);
    waitc(3);
    rd(`CDB_OFF_BRK, 32'h0d, "moe readback");
    set_ref(1'b1);
    meas(1'b0, 1'b1, n);
    chk("main rise delay", n, 32'd4);
    set_ref(1'b0);
    meas(1'b1, 1'b1, n);
    chk("comp rise delay", n, 32'd4);
    chk("main while ref low", {31'h0, main_o[0]}, 32'h0);
    set_ref(1'b1);
    waitc(2);
    ref_w[0] <= 1'b0;
    hi = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1;
      hi = hi | main_o[0];
    end
    chk("short pulse", {31'h0, hi}, 32'h0);
    wr(`CDB_OFF_POL, 32'h2);
    chk("pins ch1", {30'h0, main_o[1], comp_o[1]}, 32'h2);
    $display("test deadtime done");
    wr(`CDB_OFF_ENA, 32'h0100);
    wr(`CDB_OFF_EVT, 32'h1);
    set_ref(1'b1);
    meas(1'b1, 1'b1, n);
    chk("redirect delay", n, 32'd1);
    chk("main off", {29'h0, main_o[0], main_oe[0], comp_oe[0]}, 32'h1);
    wr(`CDB_OFF_ENA, 32'h0101);
    wr(`CDB_OFF_EVT, 32'h1);
    $display("test redirect done");
    wr(`CDB_OFF_IRQ, 32'h3);
    wr(`CDB_OFF_STAT, 32'h0);
    waitc(8);
    @(posedge clk);
    alarm <= 1'b1;
    #1;
    chk("break pins", {30'h0, main_o[0], comp_o[0]}, 32'h0);
    waitc(6);
    rd(`CDB_OFF_STAT, 32'h6, "break flag");
    chk("brk irq", {31'h0, brk_irq}, 32'h1);
    wr(`CDB_OFF_STAT, 32'h0);
    rd(`CDB_OFF_STAT, 32'h6, "flag held");
    wr(`CDB_OFF_BRK, 32'h0d);
    waitc(3);
    rd(`CDB_OFF_BRK, 32'h0c, "moe held low");
    chk("oe released", {24'h0, main_oe, comp_oe}, 32'h0);
    wr(`CDB_OFF_BRK, 32'h1c);
    waitc(1);
    chk("oe kept", {24'h0, main_oe, comp_oe}, 32'hff);
    alarm <= 1'b0;
    waitc(4);
    wr(`CDB_OFF_STAT, 32'h0);
    rd(`CDB_OFF_STAT, 32'h0, "flag cleared");
    wr(`CDB_OFF_BRK, 32'h0e);
    waitc(3);
    rd(`CDB_OFF_BRK, 32'h0e, "moe before update");
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    waitc(3);
    rd(`CDB_OFF_BRK, 32'h0f, "moe auto set");
    $display("test break done");
    @(posedge clk);
    rst_n <= 1'b0;
    waitc(3);
    rst_n <= 1'b1;
    wr(`CDB_OFF_BRK, 32'h4c);
    wr(`CDB_OFF_DT, 32'h5);
    rd(`CDB_OFF_DT, 32'h0, "dt locked");
    wr(`CDB_OFF_BRK, 32'h0);
    rd(`CDB_OFF_BRK, 32'h4c, "brk locked");
    chk("no overlap", {31'h0, shoot}, 32'h0);
    $display("test lock done");
    results();
  end
endmodule

`default_nettype wire
